// file: hw/sbc_bank_fsm.sv
// Four-bank command decoder, bank states and clock-enable logic
`timescale 1ns/1ns
module sbc_bank_fsm #(
  parameter int NUM_BANKS = 4,
  parameter int ROW_W     = 13,
  parameter int COL_W     = 10,
  parameter int BURST     = sbc_pkg::BURST_LEN,
  parameter int FIFO_D    = 8
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         clock_enable,
  input  wire logic                         chip_select_n,
  input  wire logic                         row_strobe_n,
  input  wire logic                         column_strobe_n,
  input  wire logic                         write_strobe_n,
  input  wire logic [$clog2(NUM_BANKS)-1:0] bank_select,
  input  wire logic [ROW_W-1:0]             address,
  input  wire logic                         auto_precharge_flag,
  output logic      [9*NUM_BANKS-1:0]       bank_state,
  output logic      [5:0]                   dev_state,
  output logic                              illegal_cmd,
  output logic                              col_valid,
  input  wire logic                         col_ready,
  output logic      [$clog2(NUM_BANKS)+COL_W+1:0] col_data
);
  localparam int BW = $clog2(NUM_BANKS);
  localparam int CW = sbc_pkg::CNT_W;
  localparam int EW = BW + COL_W + 2;

  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  logic [3:0] cmd;
  logic       cke_prev;
  logic       is_nop;
  assign cmd    = {chip_select_n, row_strobe_n, column_strobe_n,
                   write_strobe_n};
  assign is_nop = chip_select_n || (cmd == sbc_pkg::CMD_NOP);

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'((n < 1) ? 1 : n);
  endfunction : cyc

  // --------------------------------------------------------------
  // Bank and device state
  // --------------------------------------------------------------
  sbc_pkg::sbc_bank_e bank      [NUM_BANKS];
  sbc_pkg::sbc_bank_e next_bank [NUM_BANKS];
  logic [CW-1:0]      bcnt      [NUM_BANKS];
  logic [CW-1:0]      next_bcnt [NUM_BANKS];
  logic [ROW_W-1:0]   row_addr      [NUM_BANKS];
  logic [ROW_W-1:0]   next_row_addr [NUM_BANKS];
  sbc_pkg::sbc_dev_e  dev;
  sbc_pkg::sbc_dev_e  next_dev;
  logic [CW-1:0]      dcnt;
  logic [CW-1:0]      next_dcnt;
  logic               sr_exit;
  logic               next_sr_exit;
  logic               next_illegal;
  logic               all_idle;
  logic               push;
  logic [EW-1:0]      push_data;
  logic               fifo_ready;
  logic               fifo_valid;
  logic [EW-1:0]      fifo_data;

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bank[b] != sbc_pkg::BANK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  always_comb begin
    logic sel;
    logic run;
    sel = 1'b0;
    run = 1'b0;
    next_illegal = 1'b0;
    push         = 1'b0;
    push_data    = {BW'(bank_select), address[COL_W-1:0],
                    auto_precharge_flag, ~write_strobe_n};
    next_dev     = dev;
    next_dcnt    = (dcnt != '0) ? dcnt - 1'b1 : dcnt;
    next_sr_exit = sr_exit;
    // Banks advance on their own counters every cycle
    for (int b = 0; b < NUM_BANKS; b++) begin
      next_bank[b]     = bank[b];
      next_row_addr[b] = row_addr[b];
      next_bcnt[b]     = (bcnt[b] != '0) ? bcnt[b] - 1'b1 : bcnt[b];
      if (bcnt[b] <= 1) begin
        unique case (bank[b])
          sbc_pkg::BANK_ACTVG:   next_bank[b] = sbc_pkg::BANK_ACTIVE;
          sbc_pkg::BANK_READ,
          sbc_pkg::BANK_WRITE:   next_bank[b] = sbc_pkg::BANK_ACTIVE;
          sbc_pkg::BANK_READ_A:  begin
            next_bank[b] = sbc_pkg::BANK_PRE;
            next_bcnt[b] = cyc(sbc_pkg::PRECHARGE_CYC);
          end
          sbc_pkg::BANK_WRITE_A: begin
            next_bank[b] = sbc_pkg::BANK_WREC;
            next_bcnt[b] = cyc(sbc_pkg::WR_CLK);
          end
          sbc_pkg::BANK_WREC:    begin
            next_bank[b] = sbc_pkg::BANK_PRE;
            next_bcnt[b] = cyc(sbc_pkg::PRECHARGE_CYC);
          end
          sbc_pkg::BANK_PRE:     next_bank[b] = sbc_pkg::BANK_IDLE;
          default:               ;
        endcase
      end
    end
    // Device level: refresh, mode access, low power
    unique case (dev)
      sbc_pkg::DEV_RUN: run = cke_prev;
      sbc_pkg::DEV_REF, sbc_pkg::DEV_MRS: begin
        if (cke_prev && !is_nop) begin
          next_illegal = 1'b1;
        end
        if (dcnt <= 1) begin
          next_dev = sbc_pkg::DEV_RUN;
        end
      end
      sbc_pkg::DEV_PD: begin
        if (!cke_prev && clock_enable) begin
          if (is_nop) begin
            next_dev = sbc_pkg::DEV_RUN;
          end else begin
            next_illegal = 1'b1;
          end
        end
      end
      sbc_pkg::DEV_SR: begin
        if (sr_exit) begin
          // Second edge after the rise starts the exit timing
          next_sr_exit = 1'b0;
          next_dev     = sbc_pkg::DEV_REF;
          next_dcnt    = cyc(sbc_pkg::ROW_CYCLE_CYC);
        end else if (!cke_prev && clock_enable) begin
          if (is_nop) begin
            next_sr_exit = 1'b1;
          end else begin
            next_illegal = 1'b1;
          end
        end
      end
      default: next_dev = sbc_pkg::DEV_RUN;
    endcase
    // Commands in normal operation
    if (run) begin
      if (!clock_enable) begin
        if (!all_idle) begin
          next_illegal = 1'b1;
        end else if (is_nop) begin
          next_dev = sbc_pkg::DEV_PD;
        end else if (cmd == sbc_pkg::CMD_REF) begin
          next_dev = sbc_pkg::DEV_SR;
        end else begin
          next_illegal = 1'b1;
        end
      end else if (cmd == sbc_pkg::CMD_REF || cmd == sbc_pkg::CMD_MRS) begin
        if (!all_idle) begin
          next_illegal = 1'b1;
        end else if (cmd == sbc_pkg::CMD_REF) begin
          next_dev  = sbc_pkg::DEV_REF;
          next_dcnt = cyc(sbc_pkg::ROW_CYCLE_CYC);
        end else begin
          next_dev  = sbc_pkg::DEV_MRS;
          next_dcnt = cyc(sbc_pkg::MRD_CLK);
        end
      end else if (!is_nop) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
          sel = (BW'(b) == bank_select);
          if (sel) begin
            unique case (bank[b])
              sbc_pkg::BANK_IDLE: begin
                if (cmd == sbc_pkg::CMD_ACT) begin
                  next_bank[b]     = sbc_pkg::BANK_ACTVG;
                  next_row_addr[b] = address;
                  next_bcnt[b]     = cyc(sbc_pkg::ACT_COL_CYC);
                end else if (cmd != sbc_pkg::CMD_PRE) begin
                  next_illegal = 1'b1;
                end
              end
              sbc_pkg::BANK_PRE: begin
                if (cmd != sbc_pkg::CMD_PRE) begin
                  next_illegal = 1'b1;
                end
              end
              sbc_pkg::BANK_ACTIVE, sbc_pkg::BANK_READ,
              sbc_pkg::BANK_WRITE: begin
                if (cmd == sbc_pkg::CMD_READ
                    || cmd == sbc_pkg::CMD_WRITE) begin
                  // New column command ends any running burst that has no auto precharge
                  push         = 1'b1;
                  next_bcnt[b] = cyc(BURST);
                  next_bank[b] = (cmd == sbc_pkg::CMD_READ)
                    ? (auto_precharge_flag ? sbc_pkg::BANK_READ_A
                                           : sbc_pkg::BANK_READ)
                    : (auto_precharge_flag ? sbc_pkg::BANK_WRITE_A
                                           : sbc_pkg::BANK_WRITE);
                  if (!fifo_ready) begin
                    next_illegal = 1'b1;
                  end
                end else if (cmd == sbc_pkg::CMD_STOP) begin
                  // Stop on an open row without burst is a no-operation
                  next_bank[b] = sbc_pkg::BANK_ACTIVE;
                  next_bcnt[b] = '0;
                end else if (cmd == sbc_pkg::CMD_PRE) begin
                  next_bank[b] = sbc_pkg::BANK_PRE;
                  next_bcnt[b] = cyc(sbc_pkg::PRECHARGE_CYC);
                end else begin
                  next_illegal = 1'b1;
                end
              end
              default: next_illegal = 1'b1;
            endcase
          end
        end
      end
    end
  end

  // --------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank[b]     <= sbc_pkg::BANK_IDLE;
        bcnt[b]     <= '0;
        row_addr[b] <= '0;
      end
      dev         <= sbc_pkg::DEV_RUN;
      dcnt        <= '0;
      sr_exit     <= 1'b0;
      cke_prev    <= 1'b1;
      illegal_cmd <= 1'b0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank[b]     <= next_bank[b];
        bcnt[b]     <= next_bcnt[b];
        row_addr[b] <= next_row_addr[b];
      end
      dev         <= next_dev;
      dcnt        <= next_dcnt;
      sr_exit     <= next_sr_exit;
      cke_prev    <= clock_enable;
      illegal_cmd <= next_illegal;
    end
  end

  // --------------------------------------------------------------
  // Column command queue and registered outputs
  // --------------------------------------------------------------
  sbc_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_D)
  ) u_col_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (col_ready && !col_valid),
    .out_data  (fifo_data)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bank_state <= '0;
      dev_state  <= '0;
      col_valid  <= 1'b0;
      col_data   <= '0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_state[9*b +: 9] <= next_bank[b];
      end
      dev_state <= {next_sr_exit, next_dev};
      col_valid <= fifo_valid && col_ready && !col_valid;
      col_data  <= fifo_data;
    end
  end

endmodule : sbc_bank_fsm

// file: hw/sbc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sbc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid && (count != (AW+1)'(DEPTH));
    pop         = out_ready && (count != '0);
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1)
                       : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1)
                      : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

endmodule : sbc_fifo

// file: hw/sbc_pkg.sv
// Constants and types for the bank command state machine
package sbc_pkg;

  localparam int CLK_MHZ        = 10;
  localparam int PRECHARGE_NS   = 20;
  localparam int ACT_COL_NS     = 15;
  localparam int ROW_CYCLE_NS   = 65;
  localparam int MRD_CLK        = 2;
  localparam int WR_CLK         = 2;
  localparam int SREX_EDGES     = 2;
  localparam int PRECHARGE_CYC  = (PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACT_COL_CYC    = (ACT_COL_NS * CLK_MHZ + 999) / 1000;
  localparam int ROW_CYCLE_CYC  = (ROW_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int BURST_LEN      = 4;
  localparam int CNT_W          = 8;

  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_STOP  = 4'h6;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_MRS   = 4'h0;

  typedef enum logic [8:0] {
    BANK_IDLE   = 9'h001,
    BANK_ACTVG  = 9'h002,
    BANK_ACTIVE = 9'h004,
    BANK_READ   = 9'h008,
    BANK_WRITE  = 9'h010,
    BANK_READ_A = 9'h020,
    BANK_WRITE_A= 9'h040,
    BANK_WREC   = 9'h080,
    BANK_PRE    = 9'h100
  } sbc_bank_e;

  typedef enum logic [4:0] {
    DEV_RUN  = 5'h01,
    DEV_REF  = 5'h02,
    DEV_MRS  = 5'h04,
    DEV_PD   = 5'h08,
    DEV_SR   = 5'h10
  } sbc_dev_e;

endpackage : sbc_pkg

// file: tb/sbc_bank_chk.sv
// Checker for the bank command state machine
`timescale 1ns/1ns
module sbc_bank_chk #(
  parameter int NUM_BANKS = 4
) (
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic                         clock_enable,
  input wire logic                         chip_select_n,
  input wire logic                         row_strobe_n,
  input wire logic                         column_strobe_n,
  input wire logic                         write_strobe_n,
  input wire logic [$clog2(NUM_BANKS)-1:0] bank_select,
  input wire logic                         auto_precharge_flag,
  input wire logic [9*NUM_BANKS-1:0]       bank_state,
  input wire logic [5:0]                   dev_state,
  input wire logic                         illegal_cmd
);
  // ---------------------------------------------------------------
  // Helper decode
  // ---------------------------------------------------------------
  logic [3:0]                   cmd;
  logic [$clog2(NUM_BANKS)-1:0] bs_q;
  logic                         cke_q;
  logic                         go;
  logic                         nop;
  logic                         idle;
  logic [8:0]                   sel;
  logic [8:0]                   nsel;
  logic [8:0]                   b0;
  assign cmd  = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  assign sel  = bank_state[9*bank_select +: 9];
  assign nsel = bank_state[9*bs_q +: 9];
  assign b0   = bank_state[8:0];
  assign nop  = chip_select_n | (cmd == sbc_pkg::CMD_NOP);
  assign idle = bank_state == {NUM_BANKS{9'h001}};
  assign go   = dev_state[0] & cke_q & clock_enable;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bs_q  <= '0;
      cke_q <= 1'b1;
    end else begin
      bs_q  <= bank_select;
      cke_q <= clock_enable;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_act_opens :
    assert property (go && cmd == sbc_pkg::CMD_ACT && sel == 9'h001
      |=> nsel == sbc_pkg::BANK_ACTVG) else $error("activate lost");
  a_read_start :
    assert property (go && cmd == sbc_pkg::CMD_READ && |(sel & 9'h01c)
      |=> nsel == ($past(auto_precharge_flag) ? 9'h020 : 9'h008))
      else $error("read not started");
  a_write_start :
    assert property (go && cmd == sbc_pkg::CMD_WRITE && |(sel & 9'h01c)
      |=> nsel == ($past(auto_precharge_flag) ? 9'h040 : 9'h010))
      else $error("write not started");
  a_burst_end :
    assert property ((go && cmd == sbc_pkg::CMD_READ && b0 == 9'h004
      && bank_select == 0 && !auto_precharge_flag) ##1 (nop && go)[*4]
      |=> b0 == sbc_pkg::BANK_ACTIVE) else $error("burst length wrong");
  a_stop_burst :
    assert property (go && cmd == sbc_pkg::CMD_STOP && |(sel & 9'h018)
      |=> nsel == sbc_pkg::BANK_ACTIVE) else $error("stop ignored");
  a_pre_timer :
    assert property (b0 == 9'h100 |=> b0 == 9'h001)
      else $error("precharge time wrong");
  a_actvg_done :
    assert property (b0 == 9'h002 |=> b0 == sbc_pkg::BANK_ACTIVE)
      else $error("activate delay wrong");
  a_actvg_ill :
    assert property (go && sel == 9'h002 && !nop |=> illegal_cmd)
      else $error("illegal not flagged");
  a_ref_time :
    assert property (go && cmd == sbc_pkg::CMD_REF && idle
      |=> dev_state[1] ##1 dev_state[0]) else $error("refresh time");
  a_pre_noop :
    assert property (go && cmd == sbc_pkg::CMD_PRE && sel == 9'h001
      |=> nsel == 9'h001 && !illegal_cmd) else $error("precharge idle");
  a_pd_enter :
    assert property (dev_state[0] && cke_q && !clock_enable && nop && idle
      |=> dev_state[3]) else $error("no power-down");
  a_sr_exit :
    assert property (dev_state[4] && !cke_q && clock_enable && nop
      |=> dev_state[5] ##1 dev_state[1] ##[1:8] dev_state[0])
      else $error("self-refresh exit wrong");
  a_pd_exit :
    assert property (dev_state[3] && clock_enable && nop |=> dev_state[0])
      else $error("power-down exit wrong");
  a_pd_hold :
    assert property (|dev_state[4:3] && !clock_enable
      |=> dev_state[4:3] == $past(dev_state[4:3])) else $error("left sleep");
  c_read  : cover property (go && cmd == sbc_pkg::CMD_READ);
  c_pdown : cover property (dev_state[3]);
  c_srex  : cover property (dev_state[5]);
endmodule : sbc_bank_chk

bind sbc_bank_fsm sbc_bank_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .clock_enable(clock_enable),
  .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
  .bank_select(bank_select), .auto_precharge_flag(auto_precharge_flag),
  .bank_state(bank_state), .dev_state(dev_state),
  .illegal_cmd(illegal_cmd));

// file: tb/sbc_bank_fsm_tb_top.sv
// Testbench for the bank command state machine
`timescale 1ns/1ns
module sbc_bank_fsm_tb_top;
  // ---------------------------------------------------------------
  // Signals, design and consumer
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clock_enable = 1'b1;
  logic [3:0]  cmd = sbc_pkg::CMD_NOP;
  logic [1:0]  bank_select = '0;
  logic [12:0] address = '0;
  logic        auto_precharge_flag = 1'b0;
  logic        stall = 1'b0;
  logic        slow = 1'b1;
  logic [35:0] bank_state;
  logic [5:0]  dev_state;
  logic        illegal_cmd;
  logic        col_valid;
  logic        col_ready;
  logic [13:0] col_data;
  logic [13:0] exp_q[$];
  int          failures = 0;
  int          n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  sbc_bank_fsm u_dut (.sys_clk(sys_clk), .rst(rst),
    .clock_enable(clock_enable), .chip_select_n(cmd[3]),
    .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]),
    .write_strobe_n(cmd[0]), .bank_select(bank_select),
    .address(address), .auto_precharge_flag(auto_precharge_flag),
    .bank_state(bank_state), .dev_state(dev_state),
    .illegal_cmd(illegal_cmd), .col_valid(col_valid),
    .col_ready(col_ready), .col_data(col_data));
  sbc_col_sink u_sink (.sys_clk(sys_clk), .stall(stall), .slow(slow),
    .col_ready(col_ready));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] expv);
    n_checks++;
    if (seen !== expv) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic issue(input logic [3:0] c, input int b, input logic ap);
    @(negedge sys_clk);
    cmd = c;
    bank_select = b[1:0];
    auto_precharge_flag = ap;
    address = 13'($urandom);
    if (c == sbc_pkg::CMD_READ || c == sbc_pkg::CMD_WRITE)
      exp_q.push_back({b[1:0], address[9:0], ap, c == sbc_pkg::CMD_WRITE});
  endtask : issue
  task automatic nops(input int n);
    repeat (n) issue(sbc_pkg::CMD_NOP, 0, 1'b0);
  endtask : nops
  function automatic logic [8:0] get(input int w);
    return w < 4 ? bank_state[9*w +: 9] : 9'(dev_state);
  endfunction : get
  task automatic wait_on(input int w, input logic [8:0] e);
    int i;
    for (i = 0; i < 40 && get(w) !== e; i++) nops(1);
    check(get(w), e);
    if (i == 40) give_verdict();
  endtask : wait_on
  task automatic drain();
    int i;
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(negedge sys_clk);
    check(exp_q.size(), 0);
    if (i == 100) give_verdict();
  endtask : drain
  // ---------------------------------------------------------------
  // Column queue monitor
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (col_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check(col_data, exp_q.pop_front());
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    int         i;
    int         b;
    int         pb;
    logic [3:0] c;
    logic [3:0] pc;
    void'($urandom(32'h1f2f));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    nops(1);
    check(bank_state, {4{9'h001}});
    for (b = 0; b < 4; b++) begin
      issue(sbc_pkg::CMD_ACT, b, 1'b0);
      issue(sbc_pkg::CMD_ACT, b, 1'b0);
      check(get(b), sbc_pkg::BANK_ACTVG);
      nops(1);
      check(illegal_cmd, 1'b1);
      check(get(b), sbc_pkg::BANK_ACTIVE);
      if (b < 3) check(get(b + 1), sbc_pkg::BANK_IDLE);
    end
    stall = 1'b1;
    for (i = 0; i < 9; i++) begin
      c = $urandom_range(1) ? sbc_pkg::CMD_READ : sbc_pkg::CMD_WRITE;
      if (i < 8) issue(c, $urandom_range(3), 1'b0);
      else nops(1);
      if (i > 0) check(get(pb),
                       pc == 4'h5 ? 9'h008 : 9'h010);
      pb = bank_select;
      pc = c;
    end
    stall = 1'b0;
    drain();
    issue(sbc_pkg::CMD_READ, 0, 1'b0);
    issue(sbc_pkg::CMD_STOP, 0, 1'b0);
    nops(1);
    check(get(0), sbc_pkg::BANK_ACTIVE);
    issue(sbc_pkg::CMD_STOP, 0, 1'b0);
    nops(1);
    check({illegal_cmd, get(0)}, 10'h004);
    for (b = 0; b < 2; b++) begin
      issue(b ? sbc_pkg::CMD_WRITE : sbc_pkg::CMD_READ, b, 1'b0);
      nops(4);
      check(get(b), b ? 9'h010 : 9'h008);
      nops(1);
      check(get(b), sbc_pkg::BANK_ACTIVE);
    end
    for (b = 2; b < 4; b++) begin
      issue(b == 3 ? sbc_pkg::CMD_WRITE : sbc_pkg::CMD_READ, b, 1'b1);
      nops(1);
      check(get(b), b == 3 ? 9'h040 : 9'h020);
      wait_on(b, sbc_pkg::BANK_IDLE);
    end
    issue(sbc_pkg::CMD_REF, 0, 1'b0);
    nops(1);
    check({illegal_cmd, get(4)}, 10'h201);
    issue(sbc_pkg::CMD_PRE, 0, 1'b0);
    nops(1);
    check(get(0), sbc_pkg::BANK_PRE);
    nops(2);
    check(get(0), sbc_pkg::BANK_IDLE);
    issue(sbc_pkg::CMD_PRE, 0, 1'b0);
    nops(1);
    check({illegal_cmd, get(0)}, 10'h001);
    issue(sbc_pkg::CMD_PRE, 1, 1'b0);
    wait_on(1, sbc_pkg::BANK_IDLE);
    issue(sbc_pkg::CMD_REF, 0, 1'b0);
    nops(1);
    check(get(4), 9'h002);
    wait_on(4, 9'h001);
    issue(sbc_pkg::CMD_MRS, 0, 1'b0);
    nops(1);
    check(get(4), 9'h004);
    issue(sbc_pkg::CMD_ACT, 0, 1'b0);
    nops(1);
    check({illegal_cmd, get(0)}, 10'h201);
    nops(2);
    clock_enable = 1'b0;
    issue(sbc_pkg::CMD_ACT, 0, 1'b0);
    nops(1);
    check(get(4), 9'h008);
    clock_enable = 1'b1;
    check({illegal_cmd, get(0)}, 10'h001);
    nops(1);
    check(get(4), 9'h001);
    issue(sbc_pkg::CMD_REF, 0, 1'b0);
    clock_enable = 1'b0;
    nops(2);
    check(get(4), 9'h010);
    clock_enable = 1'b1;
    nops(1);
    check(dev_state[5], 1'b1);
    wait_on(4, 9'h001);
    drain();
    give_verdict();
  end
endmodule : sbc_bank_fsm_tb_top

// file: tb/sbc_col_sink.sv
// Column queue consumer with stall and slow modes
`timescale 1ns/1ns
module sbc_col_sink (
  input  wire logic sys_clk,
  input  wire logic stall,
  input  wire logic slow,
  output logic      col_ready
);
  // ---------------------------------------------------------------
  // Ready changes after the falling edge only
  // ---------------------------------------------------------------
  initial col_ready = 1'b0;
  always @(negedge sys_clk) begin
    col_ready <= !stall && (!slow || $urandom_range(1) == 1);
  end
endmodule : sbc_col_sink
